/* File: sftb_pkg.sv */
// shared constants, types and state records of the special function timer blocks
package sftb_pkg;

  // clock and time base
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned BASE_TICK_MS = 10;
  localparam int unsigned BASE_TICK_CYCLES = CLK_HZ / 1000 * BASE_TICK_MS;
  localparam logic [6:0] SEC_DIV = 7'h64;
  localparam logic [5:0] MIN_DIV = 6'h3C;
  localparam logic [11:0] HOUR_DIV = 12'hE10;

  // delay setting range in hundredths of a unit
  localparam logic [13:0] DELAY_MIN = 14'h0001;
  localparam logic [13:0] DELAY_MAX = 14'h270F;
  localparam logic [13:0] DELAY_RESET = 14'h0064;

  // time of day in seconds, the value one past the last second means not set
  localparam logic [16:0] LAST_SEC = 17'h1517F;
  localparam logic [16:0] NOT_SET_SEC = 17'h15180;
  localparam logic [2:0] LAST_WDAY = 3'h6;
  localparam int unsigned ENTRY_COUNT = 127;
  localparam logic [6:0] LAST_ENTRY = 7'h7E;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ON_DELAY_CFG = 8'h04;
  localparam logic [7:0] REG_OFF_DELAY_CFG = 8'h08;
  localparam logic [7:0] REG_TIME_SEC = 8'h0C;
  localparam logic [7:0] REG_TIME_CAL = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_ENTRY_SEL = 8'h18;
  localparam logic [7:0] REG_ENTRY_ON = 8'h1C;
  localparam logic [7:0] REG_ENTRY_OFF = 8'h20;
  localparam logic [7:0] REG_ENTRY_DAY = 8'h24;
  localparam logic [7:0] REG_ENTRY_COMMIT = 8'h28;

  // field positions
  localparam int unsigned CFG_UNIT_LSB = 16;
  localparam int unsigned CAL_DAY_LSB = 8;
  localparam int unsigned CAL_MONTH_LSB = 16;
  localparam int unsigned DAY_WEND_LSB = 4;
  localparam int unsigned ENTRY_VALID_BIT = 31;

  // time unit of a delay block
  typedef enum logic [1:0] {
    UNIT_SEC = 2'h0,
    UNIT_MIN = 2'h1,
    UNIT_HOUR = 2'h2
  } sftb_unit_t;

  typedef struct packed {
    sftb_unit_t unit;
    logic [13:0] value;
  } sftb_delay_cfg_t;

  // one time switch entry
  typedef struct packed {
    logic valid;
    logic [3:0] month;
    logic [4:0] day;
    logic [2:0] wk_start;
    logic [2:0] wk_end;
    logic [16:0] on_sec;
    logic [16:0] off_sec;
  } sftb_entry_t;

  // state of the delay counter
  typedef struct packed {
    logic busy;
    logic done;
    logic [13:0] cnt;
  } sftb_timer_st_t;

  // state of the time base
  typedef struct packed {
    logic [17:0] base_cnt;
    logic [6:0] sec_cnt;
    logic [5:0] min_cnt;
    logic [11:0] hour_cnt;
    logic tick_sec;
    logic tick_min;
    logic tick_hour;
    logic tick_1s;
  } sftb_tb_st_t;

  // state of the top block
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic week_scheme;
    sftb_delay_cfg_t on_cfg;
    sftb_delay_cfg_t off_cfg;
    logic [16:0] now_sec;
    logic [2:0] now_wday;
    logic [4:0] now_day;
    logic [3:0] now_month;
    logic [6:0] sel;
    sftb_entry_t stage;
    logic on_out;
    logic off_out;
    logic pulse_out;
    logic switch_out;
    logic on_trig_q;
    logic off_trig_q;
    logic pulse_trig_q;
    logic [6:0] scan_idx;
    logic scan_acc;
  } sftb_state_t;

endpackage : sftb_pkg

/* File: sftb_time_base.sv */
// time base: hundredth-of-unit ticks for seconds, minutes and hours, plus a one second tick
`timescale 1ns/1ns
module sftb_time_base
  import sftb_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = BASE_TICK_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // tick outputs, one cycle each
  output logic tick_sec_o,
  output logic tick_min_o,
  output logic tick_hour_o,
  output logic tick_1s_o
);

  sftb_tb_st_t st;
  sftb_tb_st_t next_st;
  logic base_tick;

  // divide the clock into the 10 ms base, then into the slower units
  always_comb begin
    next_st = st;
    next_st.tick_sec = 1'b0;
    next_st.tick_min = 1'b0;
    next_st.tick_hour = 1'b0;
    next_st.tick_1s = 1'b0;
    base_tick = (st.base_cnt == 18'(BASE_CYCLES - 1));
    next_st.base_cnt = base_tick ? 18'h00000 : st.base_cnt + 18'h00001;
    if (base_tick) begin
      next_st.tick_sec = 1'b1;
      next_st.sec_cnt = (st.sec_cnt == SEC_DIV - 7'h01) ? 7'h00 : st.sec_cnt + 7'h01;
      next_st.tick_1s = (st.sec_cnt == SEC_DIV - 7'h01);
      next_st.min_cnt = (st.min_cnt == MIN_DIV - 6'h01) ? 6'h00 : st.min_cnt + 6'h01;
      next_st.tick_min = (st.min_cnt == MIN_DIV - 6'h01);
      next_st.hour_cnt = (st.hour_cnt == HOUR_DIV - 12'h001) ? 12'h000 : st.hour_cnt + 12'h001;
      next_st.tick_hour = (st.hour_cnt == HOUR_DIV - 12'h001);
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_sec_o = st.tick_sec;
  assign tick_min_o = st.tick_min;
  assign tick_hour_o = st.tick_hour;
  assign tick_1s_o = st.tick_1s;

endmodule : sftb_time_base

/* File: sftb_delay_timer.sv */
// delay counter: counts unit ticks from a start until the programmed limit
`timescale 1ns/1ns
module sftb_delay_timer
  import sftb_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic start_i,
  input wire logic run_i,
  input wire logic tick_i,
  input wire logic [13:0] limit_i,
  // result
  output logic done_o
);

  sftb_timer_st_t st;
  sftb_timer_st_t next_st;

  // a start always begins a full new delay, dropping run abandons it
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (start_i) begin
      next_st.busy = 1'b1;
      next_st.cnt = 14'h0000;
    end else if (!run_i) begin
      next_st.busy = 1'b0;
      next_st.cnt = 14'h0000;
    end else if (st.busy && tick_i) begin
      next_st.cnt = st.cnt + 14'h0001;
      if (st.cnt + 14'h0001 >= limit_i) begin
        next_st.done = 1'b1;
        next_st.busy = 1'b0;
        next_st.cnt = 14'h0000;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done_o = st.done;

endmodule : sftb_delay_timer

/* File: sftb_blocks.sv */
// special function blocks: on delay, off delay, toggle pulse relay, time of day switch
`timescale 1ns/1ns
module sftb_blocks
  import sftb_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = BASE_TICK_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // block inputs from the logic program
  input wire logic on_trig_i,
  input wire logic off_trig_i,
  input wire logic off_reset_i,
  input wire logic pulse_trig_i,
  input wire logic pulse_reset_i,
  // block outputs
  output logic on_delay_o,
  output logic off_delay_o,
  output logic pulse_o,
  output logic switch_o
);

  sftb_state_t st;
  sftb_state_t next_st;
  sftb_entry_t entry_mem [ENTRY_COUNT];
  sftb_entry_t cur;
  logic commit;
  logic wb_req;
  logic [31:0] wval;
  logic tick_sec;
  logic tick_min;
  logic tick_hour;
  logic tick_1s;
  logic on_start;
  logic on_run;
  logic on_tick;
  logic on_done;
  logic off_start;
  logic off_run;
  logic off_tick;
  logic off_done;
  logic applies;
  logic on_set;
  logic off_set;

  // pick the tick of the selected unit
  function automatic logic unit_tick(input sftb_unit_t u, input logic ts, input logic tm,
                                     input logic th);
    case (u)
      UNIT_SEC: unit_tick = ts;
      UNIT_MIN: unit_tick = tm;
      default: unit_tick = th;
    endcase
  endfunction : unit_tick

  // hold a written delay value inside the documented range
  function automatic logic [13:0] clamp_delay(input logic [13:0] v);
    if (v < DELAY_MIN) begin
      clamp_delay = DELAY_MIN;
    end else if (v > DELAY_MAX) begin
      clamp_delay = DELAY_MAX;
    end else begin
      clamp_delay = v;
    end
  endfunction : clamp_delay

  // hold a written time point inside the day, or not set
  function automatic logic [16:0] clamp_time(input logic [16:0] v);
    clamp_time = (v > NOT_SET_SEC) ? NOT_SET_SEC : v;
  endfunction : clamp_time

  // merge written bytes over the current register value
  function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge_sel = m;
  endfunction : merge_sel

  // register read map, unmapped offsets read zero
  function automatic logic [31:0] read_reg(input logic [7:0] a, input sftb_state_t s);
    logic [31:0] r;
    r = 32'h00000000;
    case (a)
      REG_CTRL: r[0] = s.week_scheme;
      REG_ON_DELAY_CFG: begin
        r[13:0] = s.on_cfg.value;
        r[CFG_UNIT_LSB +: 2] = s.on_cfg.unit;
      end
      REG_OFF_DELAY_CFG: begin
        r[13:0] = s.off_cfg.value;
        r[CFG_UNIT_LSB +: 2] = s.off_cfg.unit;
      end
      REG_TIME_SEC: r[16:0] = s.now_sec;
      REG_TIME_CAL: begin
        r[2:0] = s.now_wday;
        r[CAL_DAY_LSB +: 5] = s.now_day;
        r[CAL_MONTH_LSB +: 4] = s.now_month;
      end
      REG_STATUS: r[3:0] = {s.switch_out, s.pulse_out, s.off_out, s.on_out};
      REG_ENTRY_SEL: r[6:0] = s.sel;
      REG_ENTRY_ON: begin
        r[16:0] = s.stage.on_sec;
        r[ENTRY_VALID_BIT] = s.stage.valid;
      end
      REG_ENTRY_OFF: r[16:0] = s.stage.off_sec;
      REG_ENTRY_DAY: begin
        r[2:0] = s.stage.wk_start;
        r[DAY_WEND_LSB +: 3] = s.stage.wk_end;
        r[CAL_DAY_LSB +: 5] = s.stage.day;
        r[CAL_MONTH_LSB +: 4] = s.stage.month;
      end
      default: r = 32'h00000000;
    endcase
    read_reg = r;
  endfunction : read_reg

  // unit ticks for all delay blocks
  sftb_time_base #(
    .BASE_CYCLES(BASE_CYCLES)
  ) u_time_base (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_sec_o(tick_sec),
    .tick_min_o(tick_min),
    .tick_hour_o(tick_hour),
    .tick_1s_o(tick_1s)
  );

  // timer of the on delay
  sftb_delay_timer u_on_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(on_start),
    .run_i(on_run),
    .tick_i(on_tick),
    .limit_i(st.on_cfg.value),
    .done_o(on_done)
  );

  // timer of the off delay
  sftb_delay_timer u_off_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(off_start),
    .run_i(off_run),
    .tick_i(off_tick),
    .limit_i(st.off_cfg.value),
    .done_o(off_done)
  );

  // timer controls
  assign on_start = on_trig_i && !st.on_trig_q;
  assign on_run = on_trig_i;
  assign on_tick = unit_tick(st.on_cfg.unit, tick_sec, tick_min, tick_hour);
  assign off_start = !off_trig_i && st.off_trig_q && !off_reset_i;
  assign off_run = !off_trig_i && !off_reset_i;
  assign off_tick = unit_tick(st.off_cfg.unit, tick_sec, tick_min, tick_hour);

  // entry under scan and whether it applies today
  assign cur = entry_mem[st.scan_idx];
  assign on_set = (cur.on_sec != NOT_SET_SEC);
  assign off_set = (cur.off_sec != NOT_SET_SEC);
  always_comb begin
    if (!cur.valid) begin
      applies = 1'b0;
    end else if (st.week_scheme) begin
      applies = (st.now_wday >= cur.wk_start) && (st.now_wday <= cur.wk_end);
    end else begin
      applies = (st.now_day == cur.day) && (st.now_month == cur.month);
    end
  end

  // a request is taken only while no ack stands, so each request gets exactly one ack
  assign wb_req = cyc_i && stb_i && !st.ack;
  assign wval = merge_sel(read_reg(adr_i, st), dat_i, sel_i);
  assign commit = wb_req && we_i && (adr_i == REG_ENTRY_COMMIT);

  // next state of bus, clock, blocks and switch scan
  always_comb begin
    next_st = st;
    next_st.ack = wb_req;
    next_st.on_trig_q = on_trig_i;
    next_st.off_trig_q = off_trig_i;
    next_st.pulse_trig_q = pulse_trig_i;
    // register access
    if (wb_req) begin
      next_st.rdat = we_i ? 32'h00000000 : read_reg(adr_i, st);
    end
    // running time of day, weekday wraps Sunday to Monday at midnight
    if (tick_1s) begin
      if (st.now_sec >= LAST_SEC) begin
        next_st.now_sec = 17'h00000;
        next_st.now_wday = (st.now_wday >= LAST_WDAY) ? 3'h0 : st.now_wday + 3'h1;
      end else begin
        next_st.now_sec = st.now_sec + 17'h00001;
      end
    end
    if (wb_req && we_i) begin
      case (adr_i)
        REG_CTRL: next_st.week_scheme = wval[0];
        REG_ON_DELAY_CFG: begin
          next_st.on_cfg.value = clamp_delay(wval[13:0]);
          next_st.on_cfg.unit = sftb_unit_t'(wval[CFG_UNIT_LSB +: 2]);
        end
        REG_OFF_DELAY_CFG: begin
          next_st.off_cfg.value = clamp_delay(wval[13:0]);
          next_st.off_cfg.unit = sftb_unit_t'(wval[CFG_UNIT_LSB +: 2]);
        end
        REG_TIME_SEC: begin
          next_st.now_sec = (wval[16:0] > LAST_SEC) ? LAST_SEC : wval[16:0];
        end
        REG_TIME_CAL: begin
          next_st.now_wday = (wval[2:0] > LAST_WDAY) ? LAST_WDAY : wval[2:0];
          next_st.now_day = wval[CAL_DAY_LSB +: 5];
          next_st.now_month = wval[CAL_MONTH_LSB +: 4];
        end
        REG_ENTRY_SEL: next_st.sel = (wval[6:0] > LAST_ENTRY) ? LAST_ENTRY : wval[6:0];
        REG_ENTRY_ON: begin
          next_st.stage.on_sec = clamp_time(wval[16:0]);
          next_st.stage.valid = wval[ENTRY_VALID_BIT];
        end
        REG_ENTRY_OFF: next_st.stage.off_sec = clamp_time(wval[16:0]);
        REG_ENTRY_DAY: begin
          next_st.stage.wk_start = wval[2:0];
          next_st.stage.wk_end = wval[DAY_WEND_LSB +: 3];
          next_st.stage.day = wval[CAL_DAY_LSB +: 5];
          next_st.stage.month = wval[CAL_MONTH_LSB +: 4];
        end
        default: next_st.stage = st.stage;
      endcase
    end
    // on delay
    if (!on_trig_i) begin
      next_st.on_out = 1'b0;
    end else if (on_done) begin
      next_st.on_out = 1'b1;
    end
    // off delay
    if (off_reset_i) begin
      next_st.off_out = 1'b0;
    end else if (off_trig_i) begin
      next_st.off_out = 1'b1;
    end else if (off_done) begin
      next_st.off_out = 1'b0;
    end
    // toggle pulse relay
    if (pulse_reset_i) begin
      next_st.pulse_out = 1'b0;
    end else if (pulse_trig_i && !st.pulse_trig_q) begin
      next_st.pulse_out = !st.pulse_out;
    end
    // switch scan: entries in order, each applying one over the state so far
    // a time change reaches the output within two passes of 127 cycles
    if (applies) begin
      if (on_set && st.now_sec >= cur.on_sec && (!off_set || st.now_sec < cur.off_sec)) begin
        next_st.scan_acc = 1'b1;
      end else if (off_set && st.now_sec >= cur.off_sec) begin
        next_st.scan_acc = 1'b0;
      end
    end
    if (st.scan_idx == LAST_ENTRY) begin
      // the last writer wins, then the next pass starts from the output
      next_st.switch_out = next_st.scan_acc;
      next_st.scan_acc = next_st.switch_out;
      next_st.scan_idx = 7'h00;
    end else begin
      next_st.scan_idx = st.scan_idx + 7'h01;
    end
  end

  // state register, reset clears all outputs and block state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.on_cfg.value <= DELAY_RESET;
      st.off_cfg.value <= DELAY_RESET;
      st.stage.on_sec <= NOT_SET_SEC;
      st.stage.off_sec <= NOT_SET_SEC;
    end else begin
      st <= next_st;
    end
  end

  // entry table, loaded one entry per commit
  // a commit lands at the bus edge, the scan sees it at its next read of that entry
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < ENTRY_COUNT; i++) begin
        entry_mem[i] <= '0;
      end
    end else if (commit) begin
      entry_mem[st.sel] <= st.stage;
    end
  end

  assign dat_o = st.rdat;
  assign ack_o = st.ack;
  assign on_delay_o = st.on_out;
  assign off_delay_o = st.off_out;
  assign pulse_o = st.pulse_out;
  assign switch_o = st.switch_out;

endmodule : sftb_blocks

/* File: sftb_blocks_sva.sv */
// port checker for the special function timer blocks
`timescale 1ns/1ns
module sftb_blocks_sva
  import sftb_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus handshake
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  // block pins
  input wire logic on_trig_i,
  input wire logic off_trig_i,
  input wire logic off_reset_i,
  input wire logic pulse_trig_i,
  input wire logic pulse_reset_i,
  input wire logic on_delay_o,
  input wire logic off_delay_o,
  input wire logic pulse_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // a bus request that is taken, a toggle edge that is not reset
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_edge;
    $rose(pulse_trig_i) && !pulse_reset_i;
  endsequence

  // bus answer timing
  a_ack_after_req: assert property (s_req |=> ack_o)
    else $error("no ack one cycle after a request");
  a_ack_one_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_ack_has_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack without a request");
  // on delay only rises and stays with its trigger high
  a_on_clear: assert property (!on_trig_i |=> !on_delay_o)
    else $error("on delay output high with trigger low");
  a_on_rise_trig: assert property ($rose(on_delay_o) |-> $past(on_trig_i))
    else $error("on delay output rose without trigger");
  // off delay follows trigger at once, falls only with trigger low, reset wins
  a_off_follow: assert property (off_trig_i && !off_reset_i |=> off_delay_o)
    else $error("off delay output not set by trigger");
  a_off_fall_low: assert property ($fell(off_delay_o) |->
    !$past(off_trig_i) || $past(off_reset_i))
    else $error("off delay output fell with trigger high");
  a_off_reset_wins: assert property (off_reset_i |=> !off_delay_o)
    else $error("off delay output not cleared by reset");
  // toggle relay
  a_toggle_edge: assert property (s_edge |=> pulse_o != $past(pulse_o))
    else $error("toggle output did not invert on edge");
  a_toggle_hold: assert property (!$rose(pulse_trig_i) && !pulse_reset_i |=>
    $stable(pulse_o))
    else $error("toggle output changed without edge");
  a_toggle_reset: assert property (pulse_reset_i |=> !pulse_o)
    else $error("toggle output not cleared by reset");
endmodule : sftb_blocks_sva

bind sftb_blocks sftb_blocks_sva sftb_blocks_sva_i (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .on_trig_i(on_trig_i),
  .off_trig_i(off_trig_i), .off_reset_i(off_reset_i), .pulse_trig_i(pulse_trig_i),
  .pulse_reset_i(pulse_reset_i), .on_delay_o(on_delay_o), .off_delay_o(off_delay_o),
  .pulse_o(pulse_o));

/* File: tb_top.sv */
// self-checking bench for the special function timer blocks
`timescale 1ns/1ns
module tb_top
  import sftb_pkg::*;
;
  localparam int BASE = 10;
  localparam int DLY = 5;
  localparam int LO = (DLY - 1) * BASE;
  localparam int HI = DLY * BASE + 4;
  localparam int MLO = int'(MIN_DIV) * BASE;
  localparam int MHI = 2 * int'(MIN_DIV) * BASE + 4;
  localparam logic [31:0] DAYW = 32'h00030560;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic on_trig_i, off_trig_i, off_reset_i, pulse_trig_i, pulse_reset_i;
  logic on_delay_o, off_delay_o, pulse_o, switch_o;
  int fail_count = 0;
  int n_tests = 0;

  sftb_blocks #(.BASE_CYCLES(BASE)) sftb_blocks_i (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .on_trig_i(on_trig_i),
    .off_trig_i(off_trig_i), .off_reset_i(off_reset_i), .pulse_trig_i(pulse_trig_i),
    .pulse_reset_i(pulse_reset_i), .on_delay_o(on_delay_o), .off_delay_o(off_delay_o),
    .pulse_o(pulse_o), .switch_o(switch_o));

  // clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // counts and verdict
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  // one classic bus cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    output logic [31:0] q);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= we;
    adr_i <= adr;
    dat_i <= dat;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      test_done();
    end
    @(posedge clk_i);
  endtask : wb

  // bounded wait for a delay output to reach a level
  task automatic wait_out(input bit off, input logic lvl, input int lim, output int n);
    n = 0;
    while ((off ? off_delay_o : on_delay_o) !== lvl && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= lim) begin
      fail_count++;
      test_done();
    end
  endtask : wait_out

  task automatic t_regs();
    chk("outs_rst", 32'h0, {28'h0, on_delay_o, off_delay_o, pulse_o, switch_o});
    wb(1'b0, REG_ON_DELAY_CFG, 32'h0, rd);
    chk("on_cfg_rst", {18'h0, DELAY_RESET}, rd);
    wb(1'b1, 8'h40, 32'hFFFFFFFF, rd);
    wb(1'b0, 8'h40, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    wb(1'b1, REG_STATUS, 32'h0000000F, rd);
    wb(1'b0, REG_STATUS, 32'h0, rd);
    chk("status_ro", 32'h0, rd);
    wb(1'b1, REG_ON_DELAY_CFG, 32'h00010000, rd);
    wb(1'b0, REG_ON_DELAY_CFG, 32'h0, rd);
    chk("on_cfg_min", {14'h0, UNIT_MIN, 2'h0, DELAY_MIN}, rd);
    wb(1'b1, REG_OFF_DELAY_CFG, 32'h0000FFFF, rd);
    wb(1'b0, REG_OFF_DELAY_CFG, 32'h0, rd);
    chk("off_cfg_max", {18'h0, DELAY_MAX}, rd);
    sel_i <= 4'h4;
    wb(1'b1, REG_OFF_DELAY_CFG, 32'h00020000, rd);
    sel_i <= 4'hF;
    wb(1'b0, REG_OFF_DELAY_CFG, 32'h0, rd);
    chk("off_cfg_merge", {14'h0, UNIT_HOUR, 2'h0, DELAY_MAX}, rd);
    wb(1'b1, REG_ENTRY_ON, 32'h8001FFFF, rd);
    wb(1'b0, REG_ENTRY_ON, 32'h0, rd);
    chk("entry_not_set", {15'h4000, NOT_SET_SEC}, rd);
    wb(1'b1, REG_ON_DELAY_CFG, 32'(DLY), rd);
    wb(1'b1, REG_OFF_DELAY_CFG, 32'(DLY), rd);
  endtask : t_regs

  task automatic t_on();
    int n;
    on_trig_i <= 1'b1;
    wait_out(1'b0, 1'b1, 200, n);
    chk("on_delay_time", 32'h1, 32'(n >= LO && n <= HI));
    on_trig_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("on_delay_clear", 32'h0, {31'h0, on_delay_o});
    on_trig_i <= 1'b1;
    repeat (30) @(posedge clk_i);
    on_trig_i <= 1'b0;
    @(posedge clk_i);
    on_trig_i <= 1'b1;
    repeat (LO - 2) @(posedge clk_i);
    chk("on_delay_abort", 32'h0, {31'h0, on_delay_o});
    on_trig_i <= 1'b0;
    wb(1'b1, REG_ON_DELAY_CFG, {14'h0, UNIT_MIN, 16'h0002}, rd);
    on_trig_i <= 1'b1;
    wait_out(1'b0, 1'b1, MHI + 10, n);
    chk("on_delay_min", 32'h1, 32'(n >= MLO && n <= MHI));
    on_trig_i <= 1'b0;
  endtask : t_on

  task automatic t_off();
    int n;
    off_trig_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("off_delay_set", 32'h1, {31'h0, off_delay_o});
    off_trig_i <= 1'b0;
    wait_out(1'b1, 1'b0, 200, n);
    chk("off_delay_time", 32'h1, 32'(n >= LO && n <= HI));
    off_trig_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    off_trig_i <= 1'b0;
    repeat (30) @(posedge clk_i);
    off_trig_i <= 1'b1;
    @(posedge clk_i);
    off_trig_i <= 1'b0;
    repeat (LO - 2) @(posedge clk_i);
    chk("off_delay_retrig", 32'h1, {31'h0, off_delay_o});
    off_reset_i <= 1'b1;
    off_trig_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("off_delay_reset", 32'h0, {31'h0, off_delay_o});
    off_trig_i <= 1'b0;
    @(posedge clk_i);
    off_reset_i <= 1'b0;
    repeat (HI + 10) @(posedge clk_i);
    chk("off_delay_stopped", 32'h0, {31'h0, off_delay_o});
  endtask : t_off

  task automatic t_toggle();
    for (int i = 0; i < 3; i++) begin
      pulse_trig_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk("toggle", 32'(i % 2 == 0), {31'h0, pulse_o});
      pulse_trig_i <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
    pulse_trig_i <= 1'b1;
    pulse_reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("toggle_reset", 32'h0, {31'h0, pulse_o});
    pulse_trig_i <= 1'b0;
    pulse_reset_i <= 1'b0;
  endtask : t_toggle

  task automatic set_entry(input logic [6:0] idx, input logic [16:0] on, input logic [16:0] off,
                           input logic [31:0] day);
    wb(1'b1, REG_ENTRY_SEL, {25'h0, idx}, rd);
    wb(1'b1, REG_ENTRY_ON, {15'h4000, on}, rd);
    wb(1'b1, REG_ENTRY_OFF, {15'h4000, off}, rd);
    wb(1'b1, REG_ENTRY_DAY, day, rd);
    wb(1'b1, REG_ENTRY_COMMIT, 32'h0, rd);
  endtask : set_entry

  // set the time of day, let two table passes run, compare the switch
  task automatic sw_at(input logic [16:0] t, input logic exp, input string nm);
    wb(1'b1, REG_TIME_SEC, {15'h0, t}, rd);
    repeat (260) @(posedge clk_i);
    chk(nm, {31'h0, exp}, {31'h0, switch_o});
  endtask : sw_at

  task automatic t_switch();
    wb(1'b1, REG_TIME_CAL, 32'h00030502, rd);
    set_entry(7'h00, 17'h00064, 17'h000C8, DAYW);
    sw_at(17'h00096, 1'b1, "sw_inside");
    sw_at(17'h000FA, 1'b0, "sw_after_off");
    sw_at(17'h00078, 1'b1, "sw_inside2");
    sw_at(17'h00032, 1'b1, "sw_before_on");
    sw_at(17'h0012C, 1'b0, "sw_after_off2");
    set_entry(7'h01, 17'h000F0, NOT_SET_SEC, DAYW);
    sw_at(17'h0012C, 1'b1, "sw_only_on");
    set_entry(7'h02, NOT_SET_SEC, 17'h00118, DAYW);
    sw_at(17'h0012C, 1'b0, "sw_only_off");
    sw_at(17'h0010E, 1'b1, "sw_before_off");
    wb(1'b1, REG_TIME_CAL, 32'h00030602, rd);
    sw_at(17'h0012C, 1'b1, "sw_other_date");
    wb(1'b1, REG_CTRL, 32'h1, rd);
    sw_at(17'h0012C, 1'b0, "sw_week");
    set_entry(7'h03, 17'h00122, NOT_SET_SEC, 32'h00000063);
    sw_at(17'h0012C, 1'b0, "sw_week_out");
    set_entry(7'h7E, 17'h00122, NOT_SET_SEC, 32'h00000022);
    sw_at(17'h0012C, 1'b1, "sw_week_in");
  endtask : t_switch

  // reset in mid-run clears outputs and the entry table and loads DELAY_RESET into the delay configuration
  task automatic t_rst();
    pulse_trig_i <= 1'b1;
    off_trig_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("pre_rst", 32'h7, {29'h0, off_delay_o, pulse_o, switch_o});
    pulse_trig_i <= 1'b0;
    off_trig_i <= 1'b0;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("outs_rst2", 32'h0, {28'h0, on_delay_o, off_delay_o, pulse_o, switch_o});
    wb(1'b0, REG_OFF_DELAY_CFG, 32'h0, rd);
    chk("off_cfg_rst2", {18'h0, DELAY_RESET}, rd);
    repeat (260) @(posedge clk_i);
    chk("sw_rst2", 32'h0, {31'h0, switch_o});
  endtask : t_rst

  // main sequence
  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'hF;
    dat_i = 32'h0;
    on_trig_i = 1'b0;
    off_trig_i = 1'b0;
    off_reset_i = 1'b0;
    pulse_trig_i = 1'b0;
    pulse_reset_i = 1'b0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_on();
    t_off();
    t_toggle();
    t_switch();
    t_rst();
    test_done();
  end
endmodule : tb_top
